// *** async_wait_page_parking_irq.sv ***
// Async memory wait extension, page mode settings, bus parking and interrupts
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module async_wait_page_parking_irq
	import async_wait_pkg::*;
#(
	parameter int NUM_CS = 3,
	parameter int DATA_W = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_cs,
	input wire logic [1:0] req_burst,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_done,
	output logic [DATA_W-1:0] rd_data,
	output logic burst_linear,
	input wire logic self_refresh,
	input wire logic mem_wait_input,
	input wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0] mem_data_out,
	output logic mem_data_oe,
	output logic mem_strobe_low,
	output logic [NUM_CS-1:0] page_read_enable,
	output logic [NUM_CS*PAGE_FIELD_W-1:0] page_cfg,
	output logic sdram_init_start,
	output logic irq
);

	initial begin
		if (NUM_CS < 1 || NUM_CS > 3 || DATA_W < 8 || DATA_W > 16) begin
			$error("Unsupported chip select count or data width");
		end
	end

	// ------------------------------------------------------------
	// Wait input synchroniser and edge detect
	// ------------------------------------------------------------
	logic wait_meta_reg;
	logic wait_sync_reg;
	logic wait_prev_reg;
	// First stage feeds only the second
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_meta_reg <= 1'b0;
			wait_sync_reg <= 1'b0;
			wait_prev_reg <= 1'b0;
		end else begin
			wait_meta_reg <= mem_wait_input;
			wait_sync_reg <= wait_meta_reg;
			wait_prev_reg <= wait_sync_reg;
		end
	end
	logic wait_rise_evt;
	assign wait_rise_evt = wait_sync_reg & ~wait_prev_reg;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [31:0] wait_cfg_reg;
	logic [31:0] cs_cfg_reg [NUM_CS];
	logic [31:0] page_reg;
	logic [2:0] raw_reg;
	logic [2:0] masked_reg;
	logic [2:0] enable_reg;
	logic wr_access;
	logic rd_access;
	assign wr_access = psel & penable & pwrite;
	assign rd_access = psel & penable & ~pwrite;

	// Software-visible configuration; reset loads every reset value together
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_cfg_reg <= RST_ASYNC_WAIT_CONFIG;
			page_reg <= RST_PAGE_MODE_CONTROL;
		end else if (wr_access && paddr == ADDR_ASYNC_WAIT_CONFIG) begin
			wait_cfg_reg <= pwdata;
		end else if (wr_access && paddr == ADDR_PAGE_MODE_CONTROL) begin
			page_reg <= pwdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CS; g++) begin : gen_cs
			localparam logic [7:0] CS_ADDR = 8'(ADDR_CS_CONFIG_BASE + 4 * g);
			// Per chip select timing word
			always_ff @(posedge mclk) begin
				if (rst) begin
					cs_cfg_reg[g] <= RST_CS_CONFIG;
				end else if (wr_access && paddr == CS_ADDR) begin
					cs_cfg_reg[g] <= pwdata;
				end
			end
			// Page mode settings leave on registered outputs
			always_ff @(posedge mclk) begin
				if (rst) begin
					page_read_enable[g] <= 1'b0;
					page_cfg[g*PAGE_FIELD_W +: PAGE_FIELD_W] <= '0;
				end else begin
					page_read_enable[g] <= page_reg[g*PAGE_FIELD_W + PAGE_EN_OFS];
					page_cfg[g*PAGE_FIELD_W +: PAGE_FIELD_W] <= page_reg[g*PAGE_FIELD_W +: PAGE_FIELD_W];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Initialization kick
	// ------------------------------------------------------------
	logic init_done_reg;
	// One pulse after reset release, or on any write to the SDRAM config address
	always_ff @(posedge mclk) begin
		if (rst) begin
			init_done_reg <= 1'b0;
			sdram_init_start <= 1'b0;
		end else begin
			init_done_reg <= 1'b1;
			sdram_init_start <= ~init_done_reg | (wr_access && paddr == ADDR_SDRAM_CONFIG);
		end
	end

	// ------------------------------------------------------------
	// Strobe engine
	// ------------------------------------------------------------
	phase_t phase_reg;
	logic [5:0] count_reg;
	logic [WAIT_LIMIT_W-1:0] ext_count_reg;
	logic [1:0] cs_reg;
	logic write_reg;
	logic ew_reg;
	logic timeout_evt;
	logic [31:0] cur_cfg;
	logic [4:0] cur_setup;
	logic [5:0] cur_strobe;
	logic wait_active;
	logic [WAIT_LIMIT_W-1:0] wait_limit;
	logic sum_ok;

	always_comb begin
		cur_cfg = cs_cfg_reg[0];
		for (int i = 0; i < NUM_CS; i++) begin
			if (cs_reg == 2'(i)) begin
				cur_cfg = cs_cfg_reg[i];
			end
		end
	end
	assign cur_setup = write_reg ? {1'b0, cur_cfg[CS_WSETUP_LSB +: CS_SETUP_W]}
		: {1'b0, cur_cfg[CS_RSETUP_LSB +: CS_SETUP_W]};
	assign cur_strobe = write_reg ? cur_cfg[CS_WSTROBE_LSB +: CS_STROBE_W]
		: cur_cfg[CS_RSTROBE_LSB +: CS_STROBE_W];
	// Polarity one waits on high, zero on low
	assign wait_active = ~(wait_sync_reg ^ wait_cfg_reg[WAIT_POL_LSB]);
	assign wait_limit = wait_cfg_reg[WAIT_LIMIT_LSB +: WAIT_LIMIT_W];
	// Short setup plus strobe gives the synchroniser no time, so wait is ignored
	assign sum_ok = (7'(cur_setup) + 7'(cur_strobe)) >= 7'(STROBE_SUM_MIN);
	assign timeout_evt = (phase_reg == PH_EXTEND) && ew_reg && wait_active
		&& (ext_count_reg == wait_limit);

	// Phase sequencing with wait extension
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_reg <= PH_IDLE;
			count_reg <= '0;
			ext_count_reg <= '0;
			cs_reg <= '0;
			write_reg <= 1'b0;
			ew_reg <= 1'b0;
		end else begin
			case (phase_reg)
				PH_IDLE: begin
					if (req_valid) begin
						cs_reg <= (req_cs < 2'(NUM_CS)) ? req_cs : 2'h0;
						write_reg <= req_write;
						count_reg <= '0;
						phase_reg <= PH_SETUP;
					end
				end
				PH_SETUP: begin
					ew_reg <= cur_cfg[CS_EW_BIT] & sum_ok;
					if (count_reg >= 6'(cur_setup)) begin
						count_reg <= '0;
						phase_reg <= PH_STROBE;
					end else begin
						count_reg <= count_reg + 6'h01;
					end
				end
				PH_STROBE: begin
					ext_count_reg <= '0;
					if (count_reg + 6'h01 >= cur_strobe) begin
						phase_reg <= (ew_reg && wait_active) ? PH_EXTEND : PH_LAST;
					end else begin
						count_reg <= count_reg + 6'h01;
					end
				end
				PH_EXTEND: begin
					if (!wait_active) begin
						phase_reg <= PH_LAST;
					end else if (ext_count_reg == wait_limit) begin
						phase_reg <= PH_HOLD;
					end else begin
						ext_count_reg <= ext_count_reg + 1'b1;
					end
				end
				PH_LAST: begin
					phase_reg <= PH_HOLD;
				end
				PH_HOLD: begin
					phase_reg <= PH_IDLE;
				end
				default: begin
					phase_reg <= PH_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data bus parking and request answer
	// ------------------------------------------------------------
	logic strobe_end;
	assign strobe_end = (phase_reg == PH_LAST) || ((phase_reg == PH_EXTEND) && timeout_evt);

	// Bus released for reads, and kept released after a read in self refresh; parked with last write data otherwise
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_data_out <= '0;
			mem_data_oe <= 1'b1;
			rd_data <= '0;
			req_done <= 1'b0;
			mem_strobe_low <= 1'b0;
			burst_linear <= 1'b0;
		end else begin
			req_done <= strobe_end; // Stands in hold, so a held request is not taken twice
			mem_strobe_low <= (phase_reg == PH_STROBE) || (phase_reg == PH_EXTEND) || (phase_reg == PH_LAST);
			if (phase_reg == PH_IDLE && req_valid) begin
				// Unsupported kinds run as linear
				burst_linear <= (req_burst != BURST_WRAP);
				if (req_write) begin
					mem_data_out <= req_wdata;
					mem_data_oe <= 1'b1;
				end else begin
					mem_data_oe <= 1'b0;
				end
			end else if (strobe_end && !write_reg) begin
				rd_data <= mem_data_in;
				mem_data_oe <= ~self_refresh;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------
	logic [2:0] evt;
	logic [2:0] raw_clr;
	logic trap_evt;
	assign trap_evt = (phase_reg == PH_IDLE) && req_valid
		&& (req_burst != BURST_LINEAR) && (req_burst != BURST_WRAP);
	assign evt = {trap_evt, timeout_evt, wait_rise_evt};
	assign raw_clr = (wr_access && paddr == ADDR_IRQ_RAW_STATUS) ? pwdata[2:0] : 3'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			raw_reg <= RST_IRQ;
			masked_reg <= RST_IRQ;
		end else begin
			raw_reg <= (raw_reg & ~raw_clr) | evt;
			masked_reg <= (masked_reg & ~raw_clr) | (evt & enable_reg);
		end
	end

	// Enable set and clear share one state; set beats clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_reg <= RST_IRQ;
		end else if (wr_access && paddr == ADDR_IRQ_ENABLE_SET) begin
			enable_reg <= enable_reg | pwdata[2:0];
		end else if (wr_access && paddr == ADDR_IRQ_ENABLE_CLEAR) begin
			enable_reg <= enable_reg & ~pwdata[2:0];
		end
	end

	// Single line, held until every masked flag is gone
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |masked_reg;
		end
	end

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	logic addr_ok;
	always_comb begin
		rd_mux = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			ADDR_ASYNC_WAIT_CONFIG: rd_mux = wait_cfg_reg;
			ADDR_SDRAM_CONFIG: rd_mux = 32'h0000_0000;
			ADDR_IRQ_RAW_STATUS: rd_mux = {29'h0, raw_reg};
			ADDR_IRQ_MASKED_STATUS: rd_mux = {29'h0, masked_reg};
			ADDR_IRQ_ENABLE_SET: rd_mux = {29'h0, enable_reg};
			ADDR_IRQ_ENABLE_CLEAR: rd_mux = {29'h0, enable_reg};
			ADDR_PAGE_MODE_CONTROL: rd_mux = page_reg;
			ADDR_STATUS: rd_mux = {28'h0, wait_sync_reg, phase_reg};
			default: begin
				addr_ok = 1'b0;
				for (int i = 0; i < NUM_CS; i++) begin
					if (paddr == 8'(ADDR_CS_CONFIG_BASE + 4 * i)) begin
						rd_mux = cs_cfg_reg[i];
						addr_ok = 1'b1;
					end
				end
			end
		endcase
	end

	// Zero wait state; unmapped addresses answer with an error
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_wait_rise_raw: assert property (@(posedge mclk) disable iff (rst)
		wait_rise_evt |=> raw_reg[IRQ_WAIT_RISE]) else $error("wait rise lost");
	a_timeout_hold: assert property (@(posedge mclk) disable iff (rst)
		timeout_evt |=> phase_reg == PH_HOLD) else $error("timeout not to hold");
	a_timeout_raw: assert property (@(posedge mclk) disable iff (rst)
		timeout_evt |=> raw_reg[IRQ_TIMEOUT]) else $error("timeout flag missing");
	a_extend_only_ew: assert property (@(posedge mclk) disable iff (rst)
		phase_reg == PH_EXTEND |-> ew_reg) else $error("extend without ew");
	a_resume_last: assert property (@(posedge mclk) disable iff (rst)
		(phase_reg == PH_EXTEND && !wait_active) |=> phase_reg == PH_LAST)
		else $error("no resume at last strobe");
	a_masked_enable: assert property (@(posedge mclk) disable iff (rst)
		$rose(masked_reg[IRQ_LINE_TRAP]) |-> $past(enable_reg[IRQ_LINE_TRAP]))
		else $error("masked set while disabled");
	a_raw_clear: assert property (@(posedge mclk) disable iff (rst)
		(raw_clr[IRQ_TIMEOUT] && !evt[IRQ_TIMEOUT]) |=> !raw_reg[IRQ_TIMEOUT]
		&& !masked_reg[IRQ_TIMEOUT]) else $error("raw clear failed");
	a_irq_or: assert property (@(posedge mclk) disable iff (rst)
		##1 irq == $past(|masked_reg)) else $error("irq not masked or");
	a_park_idle: assert property (@(posedge mclk) disable iff (rst)
		(req_done && write_reg) |-> mem_data_oe) else $error("bus not parked");
	a_sr_float: assert property (@(posedge mclk) disable iff (rst)
		(strobe_end && !write_reg && self_refresh) |=> !mem_data_oe)
		else $error("bus parked in self refresh");

endmodule : async_wait_page_parking_irq

`default_nettype wire

// *** async_wait_pkg.sv ***
// Package: register map, field layout and reset values of the async wait block
package async_wait_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ASYNC_WAIT_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_SDRAM_CONFIG = 8'h08;
	localparam logic [7:0] ADDR_CS_CONFIG_BASE = 8'h10;
	localparam logic [7:0] ADDR_IRQ_RAW_STATUS = 8'h40;
	localparam logic [7:0] ADDR_IRQ_MASKED_STATUS = 8'h44;
	localparam logic [7:0] ADDR_IRQ_ENABLE_SET = 8'h48;
	localparam logic [7:0] ADDR_IRQ_ENABLE_CLEAR = 8'h4C;
	localparam logic [7:0] ADDR_PAGE_MODE_CONTROL = 8'h68;
	localparam logic [7:0] ADDR_STATUS = 8'h70;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int WAIT_LIMIT_LSB = 0;
	localparam int WAIT_LIMIT_W = 8;
	localparam int WAIT_POL_LSB = 28;
	localparam int CS_EW_BIT = 30;
	localparam int CS_RSTROBE_LSB = 20;
	localparam int CS_RSETUP_LSB = 26;
	localparam int CS_WSTROBE_LSB = 7;
	localparam int CS_WSETUP_LSB = 13;
	localparam int CS_STROBE_W = 6;
	localparam int CS_SETUP_W = 4;
	localparam int PAGE_FIELD_W = 8;
	localparam int PAGE_EN_OFS = 0;
	localparam int PAGE_SIZE_OFS = 1;
	localparam int PAGE_DEL_OFS = 2;
	localparam int PAGE_DEL_W = 6;
	localparam int IRQ_WAIT_RISE = 0;
	localparam int IRQ_TIMEOUT = 1;
	localparam int IRQ_LINE_TRAP = 2;
	localparam int NUM_IRQ = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_ASYNC_WAIT_CONFIG = 32'h1000_0080;
	localparam logic [31:0] RST_CS_CONFIG = 32'h3FFF_FFFD;
	localparam logic [31:0] RST_PAGE_MODE_CONTROL = 32'h0000_0000;
	localparam logic [2:0] RST_IRQ = 3'h0;
	localparam logic [4:0] STROBE_SUM_MIN = 5'h05;

	// Access phases of the strobe engine
	typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_EXTEND, PH_LAST, PH_HOLD} phase_t;

	// Burst addressing kinds
	localparam logic [1:0] BURST_LINEAR = 2'h0;
	localparam logic [1:0] BURST_WRAP = 2'h1;

endpackage : async_wait_pkg

// *** mem_model.sv ***
// Behavioural async memory: wait pin and read data bus
`timescale 1ns/1ps
`default_nettype none

module mem_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic strobe,
	input wire logic oe,
	input wire logic wait_pol,
	input wire logic [7:0] wait_cycles,
	input wire logic [15:0] rd_value,
	output logic wait_out,
	output logic [15:0] data_in
);
	// ------------------------------------------------------------
	// Wait and data drivers
	// ------------------------------------------------------------
	logic [7:0] cnt;

	// Count strobe cycles; the count restarts whenever strobe ends
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt <= 8'h00;
		end else begin
			cnt <= strobe ? cnt + 8'h01 : 8'h00;
		end
	end
	// Wait answers strobe with pin delay only; a register here would eat the setup budget
	assign wait_out = (strobe && cnt < wait_cycles) ? wait_pol : ~wait_pol;

	// Bus toggles every cycle while oe is high, so stale data can never match by luck
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_in <= 16'h5A5A;
		end else begin
			data_in <= oe ? ~data_in : rd_value;
		end
	end
endmodule : mem_model

`default_nettype wire

// *** async_wait_page_parking_irq_tb.sv ***
// Self-checking bench for the async wait, parking and interrupt block
`timescale 1ns/1ps
`default_nettype none

module async_wait_page_parking_irq_tb;
	import async_wait_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, wait_cycles = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, req_valid = 1'b0, req_write = 1'b0, self_refresh = 1'b0;
	logic [1:0] req_cs = 2'h0, req_burst = 2'h0;
	logic [15:0] req_wdata = 16'h0, rd_data, mem_data_in, mem_data_out, rd_value = 16'h0;
	logic req_done, burst_linear, mem_wait_input, mem_data_oe, mem_strobe_low;
	logic sdram_init_start, irq, wait_pol = 1'b1;
	logic [2:0] page_read_enable;
	logic [23:0] page_cfg;
	int fails = 0, samples_checked = 0, len, base;

	async_wait_page_parking_irq uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .req_valid, .req_write, .req_cs, .req_burst, .req_wdata,
		.req_done, .rd_data, .burst_linear, .self_refresh, .mem_wait_input, .mem_data_in,
		.mem_data_out, .mem_data_oe, .mem_strobe_low, .page_read_enable, .page_cfg,
		.sdram_init_start, .irq);
	mem_model partner (.mclk, .rst, .strobe(mem_strobe_low), .oe(mem_data_oe), .wait_pol,
		.wait_cycles, .rd_value, .wait_out(mem_wait_input), .data_in(mem_data_in));

	// Free-running clock, 4 ns period
	initial begin
		forever #2 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	// Memory request held until done; len counts cycles from take to done
	task automatic mreq(input logic w, input logic [1:0] b, input logic [15:0] d);
		int n = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_burst <= b;
		req_wdata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (req_done !== 1'b1 && n < 400);
		len = n;
		if (n >= 400) fails++;
		rd = {16'h0, rd_data};
		err = burst_linear;
		req_valid <= 1'b0;
		@(posedge mclk);
	endtask : mreq

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(mem_data_oe, 1'b1);
		chk(irq, 1'b0);
		chk(mem_data_out, 16'h0);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(sdram_init_start, 1'b1);
		@(posedge mclk);
		chk(sdram_init_start, 1'b0);
		rchk(ADDR_ASYNC_WAIT_CONFIG, RST_ASYNC_WAIT_CONFIG);
		rchk(ADDR_CS_CONFIG_BASE, RST_CS_CONFIG);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h0);
		rchk(ADDR_IRQ_ENABLE_SET, 32'h0);
		rchk(ADDR_PAGE_MODE_CONTROL, RST_PAGE_MODE_CONTROL);
		apb(1'b0, 8'hFC, 32'h0);
		chk(err, 1'b1);
		$display("reset test done");
	endtask : t_reset

	task t_irq_en;
		apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'h7);
		rchk(ADDR_IRQ_ENABLE_SET, 32'h7);
		rchk(ADDR_IRQ_ENABLE_CLEAR, 32'h7);
		apb(1'b1, ADDR_IRQ_ENABLE_CLEAR, 32'h2);
		rchk(ADDR_IRQ_ENABLE_SET, 32'h5);
		rchk(ADDR_IRQ_ENABLE_CLEAR, 32'h5);
		apb(1'b1, ADDR_IRQ_ENABLE_CLEAR, 32'h7);
		$display("enable test done");
	endtask : t_irq_en

	// Unsupported addressing while disabled, then enabled
	task t_trap;
		mreq(1'b0, 2'h2, 16'h0);
		chk(err, 1'b1);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h4);
		rchk(ADDR_IRQ_MASKED_STATUS, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h4);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h0);
		apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'h4);
		mreq(1'b1, 2'h3, 16'h1234);
		chk(err, 1'b1);
		rchk(ADDR_IRQ_MASKED_STATUS, 32'h4);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h0);
		rchk(ADDR_IRQ_MASKED_STATUS, 32'h4);
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h4);
		rchk(ADDR_IRQ_MASKED_STATUS, 32'h0);
		chk(irq, 1'b0);
		mreq(1'b0, BURST_WRAP, 16'h0);
		chk(err, 1'b0);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h0);
		$display("line trap test done");
	endtask : t_trap

	// Setup 2 and strobe 4 keep the sum above 4, so wait is seen
	task t_wait;
		apb(1'b1, ADDR_CS_CONFIG_BASE, 32'h4840_4200);
		apb(1'b1, ADDR_ASYNC_WAIT_CONFIG, 32'h1000_0010);
		apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'h2);
		mreq(1'b0, BURST_LINEAR, 16'h0);
		base = len;
		wait_cycles <= 8'h08;
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(len > base, 1'b1);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h7);
		wait_cycles <= 8'h3C;
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(len > base + 15 && len <= base + 20, 1'b1);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h3);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h7);
		apb(1'b1, ADDR_CS_CONFIG_BASE, 32'h0840_4200);
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(len, base);
		rchk(ADDR_IRQ_RAW_STATUS, 32'h1);
		// Low-active wait: model idles high, design must follow the polarity bit
		wait_pol <= 1'b0;
		apb(1'b1, ADDR_CS_CONFIG_BASE, 32'h4840_4200);
		apb(1'b1, ADDR_ASYNC_WAIT_CONFIG, 32'h0000_0010);
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(len > base + 15, 1'b1);
		// Polarity bit one now mismatches the low-active device: no wait may be inserted
		apb(1'b1, ADDR_ASYNC_WAIT_CONFIG, 32'h1000_0010);
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(len, base);
		wait_pol <= 1'b1;
		wait_cycles <= 8'h00;
		apb(1'b1, ADDR_IRQ_RAW_STATUS, 32'h7);
		$display("wait test done");
	endtask : t_wait

	task t_park;
		apb(1'b1, ADDR_CS_CONFIG_BASE, 32'h0840_4200);
		mreq(1'b1, BURST_LINEAR, 16'hA5C3);
		chk(mem_data_oe, 1'b1);
		chk(mem_data_out, 16'hA5C3);
		rd_value <= 16'h3C5A;
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(rd, 32'h3C5A);
		chk(mem_data_oe, 1'b1);
		chk(mem_data_out, 16'hA5C3);
		self_refresh <= 1'b1;
		mreq(1'b0, BURST_LINEAR, 16'h0);
		chk(mem_data_oe, 1'b0);
		self_refresh <= 1'b0;
		$display("parking test done");
	endtask : t_park

	// One byte per chip select: enable, size, delay
	task t_page;
		apb(1'b1, ADDR_PAGE_MODE_CONTROL, 32'h00F8_0B00);
		// Register first, outputs one edge later
		repeat (2) @(posedge mclk);
		chk(page_read_enable, 3'h2);
		chk(page_cfg, 24'hF8_0B00);
		rchk(ADDR_PAGE_MODE_CONTROL, 32'h00F8_0B00);
		apb(1'b1, ADDR_PAGE_MODE_CONTROL, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		chk(page_read_enable, 3'h1);
		// A configuration write restarts initialization for one cycle
		apb(1'b1, ADDR_SDRAM_CONFIG, 32'h0000_0001);
		@(posedge mclk);
		chk(sdram_init_start, 1'b1);
		@(posedge mclk);
		chk(sdram_init_start, 1'b0);
		$display("page test done");
	endtask : t_page

	// Reset lands while an access is in flight
	task t_midreset;
		apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'h7);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= 1'b0;
		repeat (6) @(posedge mclk);
		req_valid <= 1'b0;
		t_reset;
		$display("mid-run reset test done");
	endtask : t_midreset

	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task conclude;
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		t_reset;
		t_irq_en;
		t_trap;
		t_wait;
		t_park;
		t_page;
		t_midreset;
		conclude;
	end

	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		conclude;
	end
endmodule : async_wait_page_parking_irq_tb

`default_nettype wire
